// File: shared/fsc_pkg.sv
// constants and types for the flash segment controller
// assumes a 16-bit byte address space and a 50 MHz core clock
package fsc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing: figures in ns, counts derived from the clock period
    localparam int FSC_CLK_PERIOD_NS = 20;
    localparam int FSC_PROG_TIME_NS = 100;
    localparam int FSC_ERASE_TIME_NS = 1000;
    // least times, so round up to whole cycles
    localparam logic [7:0] FSC_PROG_CYC =
        8'((FSC_PROG_TIME_NS + FSC_CLK_PERIOD_NS - 1) / FSC_CLK_PERIOD_NS);
    localparam logic [7:0] FSC_ERASE_CYC =
        8'((FSC_ERASE_TIME_NS + FSC_CLK_PERIOD_NS - 1) / FSC_CLK_PERIOD_NS);

    ////////////////////////////////////////////////////////////////////////
    // array geometry
    localparam logic [15:0] FSC_MAIN_BASE = 16'h8000;
    localparam logic [15:0] FSC_MAIN_SEG_MASK = 16'hFE00; // 512-byte segments
    localparam logic [15:0] FSC_INFO_BASE = 16'h1000;
    localparam logic [15:0] FSC_INFO_TOP = 16'h10FF;
    localparam logic [15:0] FSC_INFO_SEG_MASK = 16'hFFC0; // 64-byte segments
    localparam int FSC_INFO_IDX_LSB = 6;
    localparam logic [1:0] FSC_INFO_SEG_A = 2'h3;
    localparam logic [15:0] FSC_CAL_BASE = 16'h10F8;
    localparam logic [3:0] FSC_INFO_ALL = 4'hF;
    localparam logic [3:0] FSC_INFO_NOT_A = 4'h7;

    ////////////////////////////////////////////////////////////////////////
    // control key and reset values
    localparam logic [7:0] FSC_KEY_PASS = 8'hA5; // arbitrary value
    localparam logic FSC_RST_LOCK = 1'b1;
    localparam logic FSC_RST_FLAG = 1'b0;
    localparam logic [1:0] FSC_WMASK_LO = 2'h1;
    localparam logic [1:0] FSC_WMASK_HI = 2'h2;
    localparam logic [1:0] FSC_WMASK_WORD = 2'h3;

    // request sources
    localparam logic [1:0] FSC_SRC_CPU = 2'h0;
    localparam logic [1:0] FSC_SRC_TEST = 2'h1;
    localparam logic [1:0] FSC_SRC_BOOT = 2'h2;

    typedef enum logic [2:0] {
        FSC_OP_BYTE = 3'h0,
        FSC_OP_WORD = 3'h1,
        FSC_OP_SEG = 3'h2,
        FSC_OP_MAIN = 3'h3,
        FSC_OP_ALL = 3'h4
    } fsc_op_t;

    typedef enum logic [1:0] {
        FSC_IDLE = 2'h0,
        FSC_RUN = 2'h1,
        FSC_DONE = 2'h3
    } fsc_state_t;

endpackage

// File: shared/fsc_seg_if.sv
// address decode carrier between the controller and its segment decoder
// assumes both ends run combinationally in the core clock domain
`timescale 1ns/100ps
interface fsc_seg_if;
    logic [15:0] addr;
    logic in_main;
    logic in_info;
    logic is_seg_a;
    logic is_cal;
    logic [1:0] info_idx;
    logic [15:0] seg_base;

    modport dec (input addr, output in_main, in_info, is_seg_a, is_cal, info_idx, seg_base);
    modport user (output addr, input in_main, in_info, is_seg_a, is_cal, info_idx, seg_base);
endinterface

// File: hw/fsc_seg_decode.sv
// segment decoder: classifies a byte address into array regions
// assumes the caller drives addr and reads the results in the same cycle
`timescale 1ns/100ps
module fsc_seg_decode
    import fsc_pkg::*;
(
    fsc_seg_if.dec seg
);

    // region and segment classification, purely combinational
    always_comb begin
        seg.in_main = (seg.addr >= FSC_MAIN_BASE);
        seg.in_info = (seg.addr >= FSC_INFO_BASE) && (seg.addr <= FSC_INFO_TOP);
        seg.info_idx = seg.addr[FSC_INFO_IDX_LSB +: 2];
        seg.is_seg_a = seg.in_info && (seg.info_idx == FSC_INFO_SEG_A); // [RULE3]
        // top eight bytes of the info area hold the oscillator trims
        seg.is_cal = (seg.addr >= FSC_CAL_BASE) && (seg.addr <= FSC_INFO_TOP); // [RULE8]
        if (seg.in_main) begin
            seg.seg_base = seg.addr & FSC_MAIN_SEG_MASK; // [RULE2]
        end else begin
            seg.seg_base = seg.addr & FSC_INFO_SEG_MASK; // [RULE3]
        end
    end

endmodule

// File: hw/flash_segment_controller.sv
// flash segment controller: program and erase sequencing for the array
// assumes requesters and the array strobes share core_clk; no pin inputs
//
// Operation
// [RULE1] Each program request writes exactly one byte or one 16-bit word.
// [RULE2] The main array is cut into 512-byte segments and a segment erase clears one.
// [RULE3] The info area has four 64-byte segments, A to D, each erasable alone.
// [RULE4] All main segments can be erased in one mass erase, or any one on its own.
// [RULE5] Info segments erase singly or together with the whole main array.
// [RULE6] After reset segment A refuses program and erase until unlocked; others unaffected.
// [RULE7] Software wanting the factory trims should not erase segment A after unlocking.
// [RULE8] Segment A holds the oscillator trim bytes in the top eight info addresses.
// [RULE9] The array is reachable from the test port, the boot loader and the CPU.
// [RULE10] An illegal access sets a sticky violation flag raising the NMI when enabled.
// [RULE11] A control write with a bad key requests a system reset and sets the watchdog flag.
// [RULE12] While an operation runs the block reports busy and refuses new requests.
`timescale 1ns/100ps
module flash_segment_controller
    import fsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic por_n,
    input wire logic clk_en,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [2:0] req_op,
    input wire logic [1:0] req_src,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_key,
    input wire logic ctrl_seg_a_unlock,
    input wire logic access_violation_irq_enable,
    input wire logic access_violation_clr,
    input wire logic watchdog_flag_clr,
    output logic busy,
    output logic done,
    output logic seg_a_locked,
    output logic access_violation_flag,
    output logic nmi_req,
    output logic watchdog_reset_flag,
    output logic key_violation_flag,
    output logic sys_reset_req,
    output logic arr_prog,
    output logic arr_erase_main,
    output logic [3:0] arr_erase_info,
    output logic arr_erase_seg,
    output logic [15:0] arr_addr,
    output logic [15:0] arr_wdata,
    output logic [1:0] arr_wmask,
    output logic [1:0] op_src,
    output logic op_hits_cal
);

    fsc_state_t state_r, state_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic prog_r, prog_nxt;
    logic emain_r, emain_nxt;
    logic [3:0] einfo_r, einfo_nxt;
    logic eseg_r, eseg_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic [1:0] wmask_r, wmask_nxt;
    logic [1:0] src_r, src_nxt;
    logic cal_r, cal_nxt;
    logic lock_r, lock_nxt;
    logic acc_r, acc_nxt;
    logic rstreq_r, rstreq_nxt;
    logic wdt_r, wdt_nxt;
    logic key_violation_flag_r, key_violation_flag_nxt;
    logic legal;
    logic viol_evt;
    logic key_bad;
    logic a_blocked;

    fsc_seg_if seg ();

    fsc_seg_decode u_dec (
        .seg(seg)
    );

    assign seg.addr = req_addr;

    ////////////////////////////////////////////////////////////////////////
    // request legality
    always_comb begin
        a_blocked = seg.is_seg_a && lock_r; // [RULE6]
        case (req_op)
            FSC_OP_BYTE: legal = (seg.in_main || seg.in_info) && !a_blocked; // [RULE1]
            FSC_OP_WORD: legal = (seg.in_main || seg.in_info) && !a_blocked && !req_addr[0];
            FSC_OP_SEG: legal = (seg.in_main || seg.in_info) && !a_blocked; // [RULE4]
            FSC_OP_MAIN: legal = 1'b1; // [RULE4]
            FSC_OP_ALL: legal = 1'b1; // [RULE5]
            default: legal = 1'b0;
        endcase
        // any source may ask; the source only tags the operation
        // a request while busy is an illegal access, not a queued one
        viol_evt = req_valid && ((state_r != FSC_IDLE) || !legal); // [RULE10] [RULE12]
        key_bad = ctrl_wr && (ctrl_key != FSC_KEY_PASS); // [RULE11]
    end

    assign req_ready = (state_r == FSC_IDLE); // [RULE12]
    assign busy = (state_r != FSC_IDLE); // [RULE12]
    assign done = (state_r == FSC_DONE);

    ////////////////////////////////////////////////////////////////////////
    // operation sequencer: next values
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        prog_nxt = prog_r;
        emain_nxt = emain_r;
        einfo_nxt = einfo_r;
        eseg_nxt = eseg_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        wmask_nxt = wmask_r;
        src_nxt = src_r;
        cal_nxt = cal_r;
        case (state_r)
            FSC_IDLE: begin
                if (req_valid && legal) begin
                    state_nxt = FSC_RUN;
                    addr_nxt = req_addr;
                    wdata_nxt = req_wdata;
                    src_nxt = req_src; // [RULE9]
                    cal_nxt = seg.is_cal; // [RULE8]
                    wmask_nxt = 2'h0;
                    cnt_nxt = FSC_ERASE_CYC - 8'h01;
                    case (req_op)
                        FSC_OP_BYTE: begin
                            prog_nxt = 1'b1;
                            // one lane only, chosen by the low address bit
                            wmask_nxt = req_addr[0] ? FSC_WMASK_HI : FSC_WMASK_LO; // [RULE1]
                            cnt_nxt = FSC_PROG_CYC - 8'h01;
                        end
                        FSC_OP_WORD: begin
                            prog_nxt = 1'b1;
                            wmask_nxt = FSC_WMASK_WORD; // [RULE1]
                            cnt_nxt = FSC_PROG_CYC - 8'h01;
                        end
                        FSC_OP_SEG: begin
                            addr_nxt = seg.seg_base; // [RULE2]
                            cal_nxt = seg.is_seg_a;
                            if (seg.in_main) begin
                                eseg_nxt = 1'b1; // [RULE4]
                            end else begin
                                einfo_nxt = 4'(4'h1 << seg.info_idx); // [RULE3] [RULE5]
                            end
                        end
                        FSC_OP_MAIN: begin
                            emain_nxt = 1'b1; // [RULE4]
                            cal_nxt = 1'b0;
                        end
                        default: begin
                            emain_nxt = 1'b1;
                            // a locked segment A sits out the group erase
                            einfo_nxt = lock_r ? FSC_INFO_NOT_A : FSC_INFO_ALL; // [RULE5] [RULE6]
                            cal_nxt = !lock_r;
                        end
                    endcase
                end
            end
            FSC_RUN: begin
                if (cnt_r == 8'h00) begin
                    state_nxt = FSC_DONE;
                    prog_nxt = 1'b0;
                    emain_nxt = 1'b0;
                    einfo_nxt = 4'h0;
                    eseg_nxt = 1'b0;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            FSC_DONE: state_nxt = FSC_IDLE;
            default: state_nxt = FSC_IDLE;
        endcase
    end

    // sequencer registers; clk_en low freezes everything
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_r <= FSC_IDLE;
            cnt_r <= 8'h00;
            prog_r <= 1'b0;
            emain_r <= 1'b0;
            einfo_r <= 4'h0;
            eseg_r <= 1'b0;
            addr_r <= 16'h0000;
            wdata_r <= 16'h0000;
            wmask_r <= 2'h0;
            src_r <= FSC_SRC_CPU;
            cal_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            prog_r <= prog_nxt;
            emain_r <= emain_nxt;
            einfo_r <= einfo_nxt;
            eseg_r <= eseg_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            wmask_r <= wmask_nxt;
            src_r <= src_nxt;
            cal_r <= cal_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock, violation and key flags: next values, set wins over clear
    always_comb begin
        lock_nxt = lock_r;
        if (ctrl_wr && !key_bad) begin
            lock_nxt = !ctrl_seg_a_unlock; // [RULE6]
        end
        acc_nxt = (acc_r && !access_violation_clr) || viol_evt; // [RULE10]
        rstreq_nxt = key_bad; // [RULE11]
        wdt_nxt = (wdt_r && !watchdog_flag_clr) || key_bad; // [RULE11]
        key_violation_flag_nxt = (key_violation_flag_r && !watchdog_flag_clr) || key_bad;
    end

    // lock comes back on every reset, so segment A starts protected
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lock_r <= FSC_RST_LOCK; // [RULE6]
            acc_r <= FSC_RST_FLAG;
            rstreq_r <= FSC_RST_FLAG;
        end else if (clk_en) begin
            lock_r <= lock_nxt;
            acc_r <= acc_nxt;
            rstreq_r <= rstreq_nxt;
        end
    end

    // reset-cause flags live on power-on reset, else the reset they cause wipes them
    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            wdt_r <= FSC_RST_FLAG;
            key_violation_flag_r <= FSC_RST_FLAG;
        end else if (clk_en) begin
            wdt_r <= wdt_nxt;
            key_violation_flag_r <= key_violation_flag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign nmi_req = acc_r && access_violation_irq_enable; // [RULE10]
    assign seg_a_locked = lock_r;
    assign access_violation_flag = acc_r;
    assign sys_reset_req = rstreq_r;
    assign watchdog_reset_flag = wdt_r;
    assign key_violation_flag = key_violation_flag_r;
    assign arr_prog = prog_r;
    assign arr_erase_main = emain_r;
    assign arr_erase_info = einfo_r;
    assign arr_erase_seg = eseg_r;
    assign arr_addr = addr_r;
    assign arr_wdata = wdata_r;
    assign arr_wmask = wmask_r;
    assign op_src = src_r;
    assign op_hits_cal = cal_r; // [RULE8]

endmodule

// File: bench/fsc_asserts.sv
// port checker for the flash segment controller
// assumes binding to the top module; clk_en held high during erases
`timescale 1ns/100ps
module fsc_asserts
    import fsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire logic busy,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_key,
    input wire logic access_violation_flag,
    input wire logic watchdog_reset_flag,
    input wire logic key_violation_flag,
    input wire logic sys_reset_req,
    input wire logic seg_a_locked,
    input wire logic arr_prog,
    input wire logic arr_erase_main,
    input wire logic [3:0] arr_erase_info,
    input wire logic arr_erase_seg,
    input wire logic [15:0] arr_addr,
    input wire logic [1:0] arr_wmask,
    input wire logic op_hits_cal
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    // no queueing, so the running operation must keep its address
    chk_busy_refuse: assert property (busy && req_valid && clk_en |=>
        access_violation_flag && $stable(arr_addr)) else $error("busy request taken");
    chk_lane_select: assert property ($rose(arr_prog) |-> (arr_wmask == FSC_WMASK_WORD) ?
        !arr_addr[0] : arr_wmask == (arr_addr[0] ? FSC_WMASK_HI : FSC_WMASK_LO))
        else $error("byte lane wrong");
    chk_main_align: assert property ($rose(arr_erase_seg) && arr_addr >= FSC_MAIN_BASE
        |-> arr_addr[8:0] == 9'h000) else $error("main segment base wrong");
    chk_mass_len: assert property ($rose(arr_erase_main) |-> arr_erase_main [*8] ##42
        arr_erase_main ##1 !arr_erase_main) else $error("mass erase length wrong");
    chk_group_info: assert property ($rose(arr_erase_main) && arr_erase_info != 4'h0 |->
        arr_erase_info == ($past(seg_a_locked) ? FSC_INFO_NOT_A : FSC_INFO_ALL))
        else $error("group erase info set wrong");
    // segment A may only start work when it was unlocked beforehand
    chk_lock_a: assert property ($rose(arr_erase_info[3]) || ($rose(arr_erase_seg) &&
        arr_addr == 16'h10C0) || ($rose(arr_prog) && arr_addr[15:6] == 10'h043) |->
        !$past(seg_a_locked)) else $error("locked segment touched");
    chk_cal_hit: assert property ($rose(arr_prog) |->
        op_hits_cal == (arr_addr[15:3] == 13'h021F)) else $error("trim hit wrong");
    chk_bad_key: assert property (ctrl_wr && clk_en && ctrl_key != FSC_KEY_PASS |=>
        sys_reset_req && watchdog_reset_flag && key_violation_flag)
        else $error("bad key not acted on");
endmodule
bind flash_segment_controller fsc_asserts chk (.*);

// File: bench/fsc_cpu_model.sv
// cpu side of the request port
// assumes a request is taken on an edge with req_ready high
`timescale 1ns/100ps
module fsc_cpu_model (
    input wire logic core_clk,
    input wire logic req_ready,
    output logic req_valid,
    output logic [2:0] req_op,
    output logic [1:0] req_src,
    output logic [15:0] req_addr,
    output logic [15:0] req_wdata
);
    // idle lines at time zero
    initial begin
        req_valid = 1'b0;
        req_op = 3'h0;
        req_src = 2'h0;
        req_addr = 16'h0000;
        req_wdata = 16'h0000;
    end
    ////////////////////////////////////////
    // hold until taken; one_shot offers a single edge only
    task automatic request(input logic [2:0] op, input logic [1:0] src,
            input logic [15:0] a, input logic one_shot);
        int n;
        logic seen;
        n = 0;
        req_op = op;
        req_src = src;
        req_addr = a;
        req_wdata = 16'h5AC3; // one word each time
        req_valid = 1'b1;
        // ready is read while settled, before the edge that takes the request
        do begin
            seen = req_ready;
            @(posedge core_clk);
            n++;
        end while (seen !== 1'b1 && !one_shot && n < 200);
        #1;
        req_valid = 1'b0;
        // released lines must not look like a live request
        req_addr = ~a;
        req_wdata = 16'hA53C;
    endtask
endmodule

// File: bench/testbench.sv
// self-checking bench for the flash segment controller
// assumes the cpu model owns the request port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench
    import fsc_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset_n, por_n, clk_en, ctrl_wr, ctrl_seg_a_unlock, access_violation_clr;
    logic access_violation_irq_enable, watchdog_flag_clr, req_valid, req_ready, busy, done;
    logic seg_a_locked, access_violation_flag, nmi_req, watchdog_reset_flag, key_violation_flag;
    logic sys_reset_req, arr_prog, arr_erase_main, arr_erase_seg, op_hits_cal;
    logic [7:0] ctrl_key;
    logic [2:0] req_op;
    logic [1:0] req_src, arr_wmask, op_src;
    logic [15:0] req_addr, req_wdata, arr_addr, arr_wdata;
    logic [3:0] arr_erase_info;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;

    flash_segment_controller dut (.*);
    fsc_cpu_model cpu (.*);

    ////////////////////////////////////////
    // clock and hang guard
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    task automatic ctl(input logic [7:0] key, input logic unlock);
        ctrl_key = key;
        ctrl_seg_a_unlock = unlock;
        ctrl_wr = 1'b1;
        step(1);
        ctrl_wr = 1'b0;
    endtask

    task automatic clr_av();
        access_violation_clr = 1'b1;
        step(1);
        access_violation_clr = 1'b0;
        `CHK("flag cleared", 1'b0, access_violation_flag)
    endtask

    // one accepted operation, timed from acceptance to done
    task automatic run(input logic [2:0] op, input logic [1:0] src, input logic [15:0] a,
            input logic [6:0] stb, input logic [15:0] base, input int len);
        int n;
        n = 0;
        cpu.request(op, src, a, 1'b0);
        `CHK("busy", 1'b1, busy)
        `CHK("strobes", stb, {arr_prog, arr_erase_main, arr_erase_info, arr_erase_seg})
        if (op <= FSC_OP_SEG) `CHK("address", base, arr_addr)
        `CHK("source", src, op_src)
        while (done !== 1'b1 && n < 200) begin
            step(1);
            n++;
        end
        `CHK("length", len, n)
        step(1);
        `CHK("ready", 1'b1, req_ready)
    endtask

    ////////////////////////////////////////
    // scenarios
    task automatic t_program();
        for (int s = 0; s < 3; s++) begin
            run(FSC_OP_BYTE, 2'(s), 16'h8001, 7'h40, 16'h8001, FSC_PROG_CYC);
            `CHK("odd lane", FSC_WMASK_HI, arr_wmask)
        end
        run(FSC_OP_WORD, FSC_SRC_CPU, 16'h8002, 7'h40, 16'h8002, FSC_PROG_CYC);
        `CHK("word lanes", FSC_WMASK_WORD, arr_wmask)
        `CHK("word data", 16'h5AC3, arr_wdata)
    endtask

    // info segments erase through their own strobe bits, not the main one
    task automatic t_erase();
        run(FSC_OP_SEG, FSC_SRC_CPU, 16'h83FF, 7'h01, 16'h8200, FSC_ERASE_CYC);
        run(FSC_OP_SEG, FSC_SRC_TEST, 16'h103F, 7'h02, 16'h1000, FSC_ERASE_CYC);
        run(FSC_OP_SEG, FSC_SRC_BOOT, 16'h10BF, 7'h08, 16'h1080, FSC_ERASE_CYC);
        run(FSC_OP_MAIN, FSC_SRC_CPU, 16'h8000, 7'h20, 16'h8000, FSC_ERASE_CYC);
        run(FSC_OP_ALL, FSC_SRC_CPU, 16'h8000, 7'h2E, 16'h8000, FSC_ERASE_CYC);
    endtask

    task automatic t_locked();
        access_violation_irq_enable = 1'b1;
        cpu.request(FSC_OP_BYTE, FSC_SRC_CPU, 16'h10F8, 1'b1);
        `CHK("locked program", 1'b0, arr_prog)
        `CHK("violation", 1'b1, access_violation_flag)
        `CHK("nmi raised", 1'b1, nmi_req)
        access_violation_irq_enable = 1'b0;
        step(1);
        `CHK("nmi masked", 1'b0, nmi_req)
        clr_av();
        cpu.request(FSC_OP_SEG, FSC_SRC_CPU, 16'h10C0, 1'b1);
        `CHK("locked erase", 4'h0, arr_erase_info)
        `CHK("erase refused", 1'b1, access_violation_flag)
        clr_av();
        // other refusals: odd word, unknown code, address outside the array
        cpu.request(FSC_OP_WORD, FSC_SRC_CPU, 16'h8001, 1'b1);
        `CHK("odd word", 1'b1, access_violation_flag)
        clr_av();
        cpu.request(3'h7, FSC_SRC_CPU, 16'h8000, 1'b1);
        `CHK("bad code", 1'b1, access_violation_flag)
        clr_av();
        cpu.request(FSC_OP_BYTE, FSC_SRC_CPU, 16'h2000, 1'b1);
        `CHK("outside array", 1'b1, access_violation_flag)
        `CHK("nothing run", 1'b0, busy)
        clr_av();
    endtask

    task automatic t_busy();
        cpu.request(FSC_OP_SEG, FSC_SRC_CPU, 16'h8400, 1'b0);
        step(1); // valid stays low for an edge between the two requests
        cpu.request(FSC_OP_BYTE, FSC_SRC_CPU, 16'h8001, 1'b1);
        `CHK("busy refused", 1'b1, access_violation_flag)
        `CHK("erase kept", 16'h8400, arr_addr)
        `CHK("no program", 1'b0, arr_prog)
        step(FSC_ERASE_CYC - 2);
        `CHK("erase done", 1'b1, done)
        step(1);
        `CHK("idle again", 1'b1, req_ready)
        clr_av();
    endtask

    // clk_en low must stretch a running program by the frozen cycles
    task automatic t_freeze();
        cpu.request(FSC_OP_BYTE, FSC_SRC_CPU, 16'h8003, 1'b0);
        clk_en = 1'b0;
        step(10);
        `CHK("frozen prog", 1'b1, arr_prog)
        `CHK("frozen busy", 1'b1, busy)
        clk_en = 1'b1;
        step(FSC_PROG_CYC);
        `CHK("late done", 1'b1, done)
        step(1);
    endtask

    task automatic t_key();
        ctl(8'h00, 1'b1);
        `CHK("reset request", 1'b1, sys_reset_req)
        `CHK("watchdog flag", 1'b1, watchdog_reset_flag)
        `CHK("key flag set", 1'b1, key_violation_flag)
        `CHK("still locked", 1'b1, seg_a_locked)
        step(1);
        `CHK("reset pulse", 1'b0, sys_reset_req)
        ctl(FSC_KEY_PASS, 1'b1);
        `CHK("unlocked", 1'b0, seg_a_locked)
        // the reset that a bad key asks for: lock returns, its cause survives
        reset_n = 1'b0;
        step(2);
        reset_n = 1'b1;
        `CHK("reset relock", 1'b1, seg_a_locked)
        `CHK("cause kept", 1'b1, watchdog_reset_flag)
        watchdog_flag_clr = 1'b1;
        step(1);
        watchdog_flag_clr = 1'b0;
        `CHK("key flag", 1'b0, key_violation_flag)
        `CHK("watchdog clear", 1'b0, watchdog_reset_flag)
        ctl(FSC_KEY_PASS, 1'b1);
        `CHK("unlocked again", 1'b0, seg_a_locked)
        run(FSC_OP_BYTE, FSC_SRC_CPU, 16'h10FE, 7'h40, 16'h10FE, FSC_PROG_CYC);
        `CHK("trim hit", 1'b1, op_hits_cal)
        `CHK("even lane", FSC_WMASK_LO, arr_wmask)
        run(FSC_OP_SEG, FSC_SRC_CPU, 16'h10C0, 7'h10, 16'h10C0, FSC_ERASE_CYC);
        `CHK("segment a hit", 1'b1, op_hits_cal)
        run(FSC_OP_ALL, FSC_SRC_CPU, 16'h8000, 7'h3E, 16'h8000, FSC_ERASE_CYC);
        // lock again at once so trims are not erased later
        ctl(FSC_KEY_PASS, 1'b0);
        `CHK("relocked", 1'b1, seg_a_locked)
    endtask

    ////////////////////////////////////////
    // reset, then the scenarios in turn
    initial begin
        reset_n = 1'b0;
        por_n = 1'b0;
        clk_en = 1'b1;
        ctrl_wr = 1'b0;
        ctrl_key = 8'h00;
        ctrl_seg_a_unlock = 1'b0;
        access_violation_irq_enable = 1'b0;
        access_violation_clr = 1'b0;
        watchdog_flag_clr = 1'b0;
        step(12);
        reset_n = 1'b1;
        por_n = 1'b1;
        `CHK("reset lock", 1'b1, seg_a_locked)
        `CHK("reset ready", 1'b1, req_ready)
        t_program();
        t_erase();
        t_locked();
        t_busy();
        t_freeze();
        t_key();
        stop_test();
    end
endmodule
